// ### rtl/htr_pkg.sv
// htr_pkg: constants, command and state types, checksum function for the readout core
// assumes a 100 MHz mclk and a byte/bit engine on the same clock
package htr_pkg;

  localparam int          RES_W     = 16;
  localparam logic [7:0]  CRC_POLY  = 8'h31;
  localparam logic [7:0]  CRC_INIT  = 8'hFF;
  localparam logic [7:0]  CRC_XOR   = 8'h00;

  // timing
  localparam int          CLK_NS    = 10;
  localparam int          MS_NS     = 1000000;
  localparam int          MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W     = 24;
  localparam int          MSC_W     = 12;

  // auto sampling intervals in ms, rate codes 0 to 4
  localparam logic [11:0] RATE0_MS  = 12'h7D0;
  localparam logic [11:0] RATE1_MS  = 12'h3E8;
  localparam logic [11:0] RATE2_MS  = 12'h1F4;
  localparam logic [11:0] RATE3_MS  = 12'h0FA;
  localparam logic [11:0] RATE4_MS  = 12'h064;

  // limit slots
  localparam logic [1:0]  LIM_HI_SET = 2'h0;
  localparam logic [1:0]  LIM_HI_CLR = 2'h1;
  localparam logic [1:0]  LIM_LO_SET = 2'h2;
  localparam logic [1:0]  LIM_LO_CLR = 2'h3;
  // limit word: humidity top bits high, temperature top bits low
  localparam int          LIM_H_MSB  = 15;
  localparam int          LIM_H_LSB  = 9;
  localparam int          LIM_T_MSB  = 8;
  localparam int          LIM_T_LSB  = 0;

  // status word bits
  localparam int          ST_ALERT   = 15;
  localparam int          ST_HEATER  = 13;
  localparam int          ST_AUTO    = 12;
  localparam int          ST_CRC_ERR = 0;

  typedef enum logic [3:0] {
    CMD_MEAS_ONCE, CMD_AUTO_START, CMD_AUTO_STOP, CMD_SOFT_RESET,
    CMD_HEATER_ON, CMD_HEATER_OFF, CMD_WR_LIMIT, CMD_RD_RESULT,
    CMD_RD_LIMIT, CMD_RD_STATUS, CMD_CLR_STATUS
  } htr_cmd_e;

  typedef struct packed {
    htr_cmd_e    op;
    logic [2:0]  arg;
    logic [15:0] data;
    logic [7:0]  crc;
  } htr_cmd_s;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] hum;
  } htr_res_s;

  typedef enum logic [0:0] {MS_SLEEP, MS_MEAS} htr_mst_e;
  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_ACK} htr_tst_e;

  typedef struct packed {
    htr_mst_e         mst;
    logic             auto_on;
    logic [2:0]       rate;
    logic             heater;
    logic             alert;
    logic             crc_err;
    logic             nv_loaded;
    htr_res_s         res;
    logic [3:0][15:0] lim;
    logic [CNT_W-1:0] cyc_cnt;
    logic [MSC_W-1:0] ms_cnt;
    logic             conv_start;
    htr_tst_e         tst;
    logic [1:0][15:0] tx_word;
    logic             tx_last;
    logic             tx_widx;
    logic [1:0]       tx_bidx;
    logic [7:0]       tx_sh;
    logic [3:0]       tx_bits;
    logic             nv_wr;
    logic [1:0]       nv_idx;
    logic [15:0]      nv_data;
    logic             cmd_ack;
    logic             cmd_nack;
  } htr_state_s;

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ CRC_XOR;
  endfunction

  function automatic logic [11:0] rate_ms(input logic [2:0] r);
    case (r)
      3'h0:    return RATE0_MS;
      3'h1:    return RATE1_MS;
      3'h2:    return RATE2_MS;
      3'h3:    return RATE3_MS;
      default: return RATE4_MS;
    endcase
  endfunction

endpackage

// ### rtl/htr_readout.sv
// htr_readout: measurement sequencing, threshold alert, limit store and checksummed readout
// assumes command decode, bit timing and the converter live outside on the same mclk
// How it works
// - every humidity and temperature result is an unsigned 16-bit code
// - codes map linearly: RH=100c/65535, C=-45+175c/65535, F=-49+315c/65535
// - on-demand: one command gives exactly one conversion, then sleep
// - auto mode repeats conversions at 0.5 to 10 per second without commands
// - auto mode wakes from sleep per selected interval, sleeps between conversions
// - alert asserts when a completed result falls outside the programmed window
// - threshold limits live in non-volatile storage and survive power cycles
// - four limits: high set, high clear, low set, low clear give hysteresis
// - one checksum byte follows every transmitted 16-bit word
// - each checksum covers only the two bytes just before it
// - checksum poly 0x31, init 0xFF, no reflection, final xor 0x00
// - checksum follows results, status word and every limit readback
// - controller may nack the last data byte; checksum is then dropped
// - measurements continue while the heater is on
// - every byte goes out most significant bit first
// - after power-up, reset or soft reset the core sleeps and awaits commands
`timescale 1ns/100ps
module htr_readout
  import htr_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             cmd_valid,
  input  wire htr_cmd_s         cmd,
  output logic                  cmd_ack,
  output logic                  cmd_nack,
  output logic                  conv_start,
  input  wire logic             conv_done,
  input  wire htr_res_s         conv_res,
  output logic                  meas_busy,
  output logic                  heater_en,
  output logic                  alert,
  output logic                  tx_active,
  output logic                  tx_bit,
  input  wire logic             bit_step,
  input  wire logic             ack_valid,
  input  wire logic             ack_ok,
  input  wire logic [3:0][15:0] nv_limits,
  output logic                  nv_wr,
  output logic [1:0]            nv_idx,
  output logic [15:0]           nv_data
);

  if (MS_CYC < 1 || MS_CYC >= (1 << CNT_W)) begin : g_ms_cyc_check
    $error("MS_CYC out of range");
  end

  localparam logic [CNT_W-1:0] MS_LAST = CNT_W'(MS_CYC - 1);

  htr_state_s st;
  htr_state_s next_st;

  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic [1:0] b);
    case (b)
      2'h0:    return w[15:8];
      2'h1:    return w[7:0];
      default: return crc8(w);
    endcase
  endfunction

  logic [6:0]  h7;
  logic [8:0]  t9;
  logic        out_win;
  logic        in_clr;
  logic        tx_free;
  logic        start_conv;
  logic [15:0] status_w;

  assign h7 = conv_res.hum[15:9];
  assign t9 = conv_res.temp[15:7];
  assign tx_free = (st.tst == TX_IDLE);
  assign status_w = 16'((st.alert << ST_ALERT) | (st.heater << ST_HEATER)
                        | (st.auto_on << ST_AUTO) | (st.crc_err << ST_CRC_ERR));

  // window compare on the top bits of each result
  always_comb begin
    out_win = (h7 > st.lim[LIM_HI_SET][LIM_H_MSB:LIM_H_LSB])
            | (t9 > st.lim[LIM_HI_SET][LIM_T_MSB:LIM_T_LSB])
            | (h7 < st.lim[LIM_LO_SET][LIM_H_MSB:LIM_H_LSB])
            | (t9 < st.lim[LIM_LO_SET][LIM_T_MSB:LIM_T_LSB]);
    in_clr  = (h7 <= st.lim[LIM_HI_CLR][LIM_H_MSB:LIM_H_LSB])
            & (t9 <= st.lim[LIM_HI_CLR][LIM_T_MSB:LIM_T_LSB])
            & (h7 >= st.lim[LIM_LO_CLR][LIM_H_MSB:LIM_H_LSB])
            & (t9 >= st.lim[LIM_LO_CLR][LIM_T_MSB:LIM_T_LSB]);
  end

  always_comb begin
    next_st            = st;
    next_st.conv_start = 1'b0;
    next_st.nv_wr      = 1'b0;
    next_st.cmd_ack    = 1'b0;
    next_st.cmd_nack   = 1'b0;
    start_conv         = 1'b0;

    // limits come back from non-volatile storage once after reset
    if (!st.nv_loaded) begin
      next_st.lim       = nv_limits;
      next_st.nv_loaded = 1'b1;
    end

    // auto interval timer
    if (st.auto_on) begin
      if (st.cyc_cnt == MS_LAST) begin
        next_st.cyc_cnt = '0;
        if (st.ms_cnt == rate_ms(st.rate) - 12'h001) begin
          next_st.ms_cnt = '0;
          start_conv     = 1'b1;
        end else begin
          next_st.ms_cnt = st.ms_cnt + 12'h001;
        end
      end else begin
        next_st.cyc_cnt = st.cyc_cnt + CNT_W'(1);
      end
    end

    // commands
    if (cmd_valid) begin
      next_st.cmd_ack = 1'b1;
      case (cmd.op)
        CMD_MEAS_ONCE: begin
          if (st.mst == MS_MEAS || st.auto_on) begin
            next_st.cmd_ack  = 1'b0;
            next_st.cmd_nack = 1'b1;
          end else begin
            start_conv = 1'b1;
          end
        end
        CMD_AUTO_START: begin
          if (cmd.arg > 3'h4) begin
            next_st.cmd_ack  = 1'b0;
            next_st.cmd_nack = 1'b1;
          end else begin
            next_st.auto_on = 1'b1;
            next_st.rate    = cmd.arg;
            next_st.cyc_cnt = '0;
            next_st.ms_cnt  = '0;
          end
        end
        CMD_AUTO_STOP: begin
          next_st.auto_on = 1'b0;
        end
        CMD_SOFT_RESET: begin
          next_st.mst       = MS_SLEEP;
          next_st.auto_on   = 1'b0;
          next_st.heater    = 1'b0;
          next_st.alert     = 1'b0;
          next_st.crc_err   = 1'b0;
          next_st.nv_loaded = 1'b0;
          next_st.tst       = TX_IDLE;
        end
        CMD_HEATER_ON, CMD_WR_LIMIT: begin
          if (crc8(cmd.data) != cmd.crc) begin
            next_st.cmd_ack  = 1'b0;
            next_st.cmd_nack = 1'b1;
            next_st.crc_err  = 1'b1;
          end else if (cmd.op == CMD_HEATER_ON) begin
            next_st.heater = 1'b1;
          end else begin
            next_st.lim[cmd.arg[1:0]] = cmd.data;
            next_st.nv_wr             = 1'b1;
            next_st.nv_idx            = cmd.arg[1:0];
            next_st.nv_data           = cmd.data;
          end
        end
        CMD_HEATER_OFF: begin
          next_st.heater = 1'b0;
        end
        CMD_CLR_STATUS: begin
          next_st.crc_err = 1'b0;
        end
        CMD_RD_RESULT, CMD_RD_LIMIT, CMD_RD_STATUS: begin
          if (!tx_free) begin
            next_st.cmd_ack  = 1'b0;
            next_st.cmd_nack = 1'b1;
          end else begin
            next_st.tst      = TX_BITS;
            next_st.tx_widx  = 1'b0;
            next_st.tx_bidx  = 2'h0;
            next_st.tx_bits  = 4'h0;
            next_st.tx_last  = (cmd.op != CMD_RD_RESULT);
            if (cmd.op == CMD_RD_RESULT) begin
              next_st.tx_word = {st.res.hum, st.res.temp};
            end else if (cmd.op == CMD_RD_LIMIT) begin
              next_st.tx_word = {16'h0000, st.lim[cmd.arg[1:0]]};
            end else begin
              next_st.tx_word = {16'h0000, status_w};
            end
            next_st.tx_sh = byte_of(next_st.tx_word[0], 2'h0);
          end
        end
        default: begin
          next_st.cmd_ack  = 1'b0;
          next_st.cmd_nack = 1'b1;
        end
      endcase
    end

    // soft reset abandons a conversion that would start this cycle
    if (cmd_valid && cmd.op == CMD_SOFT_RESET) begin
      start_conv = 1'b0;
    end

    // measurement sequencing; heater state has no say here
    case (st.mst)
      MS_SLEEP: begin
        if (start_conv) begin
          next_st.mst        = MS_MEAS;
          next_st.conv_start = 1'b1;
        end
      end
      MS_MEAS: begin
        if (conv_done && !(cmd_valid && cmd.op == CMD_SOFT_RESET)) begin
          next_st.mst = MS_SLEEP;
          next_st.res = conv_res;
          if (out_win) begin
            next_st.alert = 1'b1;
          end else if (in_clr) begin
            next_st.alert = 1'b0;
          end
        end
      end
      default: begin
        next_st.mst = MS_SLEEP;
      end
    endcase

    // serial readout: msb, lsb, checksum per word
    case (st.tst)
      TX_IDLE: begin
      end
      TX_BITS: begin
        if (bit_step) begin
          next_st.tx_sh   = {st.tx_sh[6:0], 1'b0};
          next_st.tx_bits = st.tx_bits + 4'h1;
          if (st.tx_bits == 4'h7) begin
            next_st.tst = TX_ACK;
          end
        end
      end
      TX_ACK: begin
        if (ack_valid) begin
          next_st.tx_bits = 4'h0;
          if (!ack_ok) begin
            next_st.tst = TX_IDLE;
          end else if (st.tx_bidx == 2'h2) begin
            if (st.tx_last || st.tx_widx) begin
              next_st.tst = TX_IDLE;
            end else begin
              next_st.tst     = TX_BITS;
              next_st.tx_widx = 1'b1;
              next_st.tx_bidx = 2'h0;
              next_st.tx_sh   = byte_of(st.tx_word[1], 2'h0);
            end
          end else begin
            next_st.tst     = TX_BITS;
            next_st.tx_bidx = st.tx_bidx + 2'h1;
            next_st.tx_sh   = byte_of(st.tx_word[st.tx_widx], st.tx_bidx + 2'h1);
          end
        end
      end
      default: begin
        next_st.tst = TX_IDLE;
      end
    endcase

    // soft reset also aborts a readout in flight
    if (cmd_valid && cmd.op == CMD_SOFT_RESET) begin
      next_st.tst = TX_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ack    = st.cmd_ack;
  assign cmd_nack   = st.cmd_nack;
  assign conv_start = st.conv_start;
  assign meas_busy  = (st.mst == MS_MEAS);
  assign heater_en  = st.heater;
  assign alert      = st.alert;
  assign tx_active  = !tx_free;
  assign tx_bit     = st.tx_sh[7];
  assign nv_wr      = st.nv_wr;
  assign nv_idx     = st.nv_idx;
  assign nv_data    = st.nv_data;

endmodule

// ### verification/htr_ctrl_model.sv
// htr_ctrl_model: controller side of the readout, pulls bytes bit by bit, acks each byte but nacks the last one
// assumes the readout core on the same mclk; want gives the bytes taken per transfer
`timescale 1ns/100ps
module htr_ctrl_model
  import htr_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            srst,
  input  wire logic            tx_active,
  input  wire logic            tx_bit,
  input  wire logic [2:0]      want,
  input  wire logic            slow,
  output logic                 bit_step,
  output logic                 ack_valid,
  output logic                 ack_ok,
  output logic [5:0][7:0]      rx,
  output logic [2:0]           rx_n
);
  initial begin
    bit_step = 1'b0;
    ack_valid = 1'b0;
    ack_ok = 1'b0;
    rx = '0;
    rx_n = 3'h0;
    forever begin
      @(posedge mclk);
      #1;
      if (tx_active && !srst) begin
        rx_n = 3'h0;
        while (rx_n < want) begin
          @(posedge mclk);
          #1;
          for (int b = 0; b < 8; b++) begin
            if (slow) begin
              bit_step = 1'b0;
              repeat (2) @(posedge mclk);
              #1;
            end
            rx[rx_n] = {rx[rx_n][6:0], tx_bit};
            bit_step = 1'b1;
            @(posedge mclk);
            #1;
          end
          bit_step = 1'b0;
          ack_valid = 1'b1;
          ack_ok = (rx_n < want - 3'h1);
          // count the byte before the edge so the bench never races the update
          rx_n = rx_n + 3'h1;
          @(posedge mclk);
          #1 ack_valid = 1'b0;
          ack_ok = ~ack_ok;
        end
      end
    end
  end
endmodule

// ### verification/htr_readout_assertions.sv
// htr_readout_checker: concurrent checks on the readout core ports
// assumes one mclk domain with synchronous active-high srst
`timescale 1ns/100ps
module htr_readout_checker
  import htr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire htr_cmd_s    cmd,
  input wire logic        cmd_ack,
  input wire logic        cmd_nack,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        meas_busy,
  input wire logic        heater_en,
  input wire logic        alert,
  input wire logic        tx_active,
  input wire logic        tx_bit,
  input wire logic        bit_step,
  input wire logic        ack_valid,
  input wire logic        ack_ok,
  input wire logic        nv_wr,
  input wire logic [1:0]  nv_idx,
  input wire logic [15:0] nv_data
);
  logic wr_cmd;
  logic crc_ok;
  assign wr_cmd = cmd_valid && cmd.op == CMD_WR_LIMIT;
  assign crc_ok = cmd.crc == crc8(cmd.data);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  answer_once_a: assert property (cmd_valid |=> cmd_ack ^ cmd_nack)
    else $error("command not answered exactly once");
  no_answer_a: assert property (!cmd_valid |=> !cmd_ack && !cmd_nack)
    else $error("answer without a command");
  once_start_a: assert property ((cmd_valid && cmd.op == CMD_MEAS_ONCE) ##1 cmd_ack |->
    conv_start && meas_busy) else $error("accepted measurement did not start");
  busy_end_a: assert property (meas_busy && conv_done |=> !meas_busy || conv_start)
    else $error("busy stayed after conversion done");
  bad_crc_a: assert property (wr_cmd && !crc_ok |=> cmd_nack && !nv_wr)
    else $error("limit with wrong checksum taken");
  limit_store_a: assert property (wr_cmd && crc_ok |=> cmd_ack && nv_wr &&
    nv_data == $past(cmd.data) && nv_idx == $past(cmd.arg[1:0]))
    else $error("limit not written to store");
  bit_hold_a: assert property ((tx_active && !bit_step && !ack_valid) ##1 tx_active
    |-> $stable(tx_bit)) else $error("bit changed without step");
  nack_stop_a: assert property (tx_active && ack_valid && !ack_ok |=> !tx_active)
    else $error("readout went on after nack");
  heater_off_a: assert property (cmd_valid && cmd.op == CMD_HEATER_OFF |=> ##1 !heater_en)
    else $error("heater still on");
  soft_sleep_a: assert property (cmd_valid && cmd.op == CMD_SOFT_RESET |-> ##2
    !meas_busy && !heater_en && !alert && !tx_active) else $error("not asleep after soft reset");
  cover property (conv_done && meas_busy);
  cover property (tx_active && ack_valid && !ack_ok);
  cover property (nv_wr);
endmodule
bind htr_readout htr_readout_checker i_htr_readout_checker (.mclk, .srst, .cmd_valid, .cmd,
  .cmd_ack, .cmd_nack, .conv_start, .conv_done, .meas_busy, .heater_en, .alert, .tx_active,
  .tx_bit, .bit_step, .ack_valid, .ack_ok, .nv_wr, .nv_idx, .nv_data);

// ### verification/htr_readout_bench.sv
// htr_readout_bench: random and corner-case stimulus for the readout core, self checking
// assumes htr_ctrl_model as controller and a four-cycle behavioural converter here
`timescale 1ns/100ps
module htr_readout_bench;
  import htr_pkg::*;
  logic             mclk, srst, cmd_valid, cmd_ack, cmd_nack, conv_start, conv_done, slow;
  logic             meas_busy, heater_en, alert, tx_active, tx_bit, bit_step, ack_valid, ack_ok;
  logic             nv_wr, resp;
  logic [1:0]       nv_idx;
  logic [15:0]      nv_data;
  logic [2:0]       want, rx_n;
  logic [3:0]       cpipe = 4'h0;
  logic [5:0][7:0]  rx;
  logic [3:0][15:0] nv_limits;
  logic [3:0][15:0] lim = {16'h4060, 16'h2040, 16'h80E0, 16'hA100};
  htr_cmd_s         cmd;
  htr_res_s         res;
  htr_res_s         atab [4] = '{32'h6000A400, 32'h60009000, 32'h60004800, 32'h10004800};
  int               ivms [5] = '{2000, 1000, 500, 250, 100};
  int               fail_count, check_count, seed, nbase;
  int               nconv = 0;
  htr_readout #(.MS_CYC(10)) i_htr_readout (.mclk, .srst, .cmd_valid, .cmd, .cmd_ack, .cmd_nack,
    .conv_start, .conv_done, .conv_res(res), .meas_busy, .heater_en, .alert, .tx_active,
    .tx_bit, .bit_step, .ack_valid, .ack_ok, .nv_limits, .nv_wr, .nv_idx, .nv_data);
  htr_ctrl_model i_htr_ctrl_model (.mclk, .srst, .tx_active, .tx_bit, .want, .slow, .bit_step,
    .ack_valid, .ack_ok, .rx, .rx_n);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // converter answers four cycles after each start
  assign conv_done = cpipe[3];
  always @(posedge mclk) begin
    cpipe <= #1 {cpipe[2:0], conv_start};
    if (conv_start === 1'b1) nconv = nconv + 1;
  end
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic send(input htr_cmd_e op, input logic [2:0] a, input logic [15:0] d,
                      input logic [7:0] c);
    // an idle edge first, so back-to-back commands never toggle cmd_valid in one step
    tick(1);
    cmd = '{op, a, d, c};
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    resp = cmd_ack;
  endtask
  task automatic rd(input htr_cmd_e op, input logic [2:0] a, input logic [2:0] n);
    want = n;
    send(op, a, 16'h0000, 8'h00);
    for (int i = 0; i < 400 && tx_active; i++) tick(1);
    check(resp === 1'b1 && rx_n === n && tx_active === 1'b0, "read length");
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #950000;
    fail_count++;
    complete_run();
  end
  initial begin
    seed = 32'h7b0c4b19;
    {fail_count, check_count, nbase} = '0;
    srst = 1'b1;
    {cmd_valid, cmd, slow, want} = '0;
    res = htr_res_s'($random(seed));
    nv_limits = {16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF};
    repeat (20) @(posedge mclk);
    #1 srst = 1'b0;
    tick(2);
    check({meas_busy, heater_en, alert, tx_active} === 4'h0, "not idle after reset");
    check(crc(16'hABCD) === 8'h6F, "checksum vector");
    send(CMD_MEAS_ONCE, 3'h0, 16'h0000, 8'h00);
    check(resp === 1'b1 && conv_start === 1'b1 && meas_busy === 1'b1, "no start");
    send(CMD_MEAS_ONCE, 3'h0, 16'h0000, 8'h00);
    check(cmd_nack === 1'b1, "busy measurement not refused");
    tick(50);
    check(nconv === 1 && meas_busy === 1'b0, "not a single conversion");
    slow = 1'b1;
    rd(CMD_RD_RESULT, 3'h0, 3'h6);
    check({rx[0], rx[1], rx[2]} === {res.temp, crc(res.temp)}, "temperature word");
    check({rx[3], rx[4], rx[5]} === {res.hum, crc(res.hum)}, "humidity word");
    slow = 1'b0;
    rd(CMD_RD_RESULT, 3'h0, 3'h2);
    check({rx[0], rx[1]} === res.temp, "short read word");
    for (int i = 0; i < 4; i++) begin
      send(CMD_WR_LIMIT, 3'(i), lim[i], crc(lim[i]));
      check(nv_wr === 1'b1 && nv_idx === 2'(i) && nv_data === lim[i], "limit store");
      rd(CMD_RD_LIMIT, 3'(i), 3'h3);
      check({rx[0], rx[1], rx[2]} === {lim[i], crc(lim[i])}, "limit readback");
    end
    send(CMD_WR_LIMIT, 3'h0, 16'h1234, crc(16'h1234) ^ 8'h01);
    check(cmd_nack === 1'b1 && nv_wr === 1'b0, "bad checksum taken");
    rd(CMD_RD_STATUS, 3'h0, 3'h3);
    check({rx[0], rx[1], rx[2]} === {16'h0001, crc(16'h0001)}, "status word");
    send(CMD_CLR_STATUS, 3'h0, 16'h0000, 8'h00);
    for (int i = 0; i < 4; i++) begin
      res = atab[i];
      send(CMD_MEAS_ONCE, 3'h0, 16'h0000, 8'h00);
      tick(8);
      check(alert === 1'(4'hB >> i), "alert level");
    end
    send(CMD_AUTO_START, 3'h5, 16'h0000, 8'h00);
    check(cmd_nack === 1'b1, "bad rate taken");
    send(CMD_HEATER_ON, 3'h0, 16'h0000, crc(16'h0000));
    check(resp === 1'b1, "heater refused");
    for (int r = 0; r < 5; r++) begin
      res = htr_res_s'($random(seed));
      send(CMD_AUTO_STOP, 3'h0, 16'h0000, 8'h00);
      tick(10);
      nbase = nconv;
      send(CMD_AUTO_START, 3'(r), 16'h0000, 8'h00);
      tick(ivms[r] * 10 - 3);
      check(nconv - nbase === 0, "auto started early");
      tick(6);
      check(nconv - nbase === 1, "auto interval");
      tick(ivms[r] * 10);
      check(nconv - nbase === 2 && heater_en === 1'b1, "auto repeat");
    end
    rd(CMD_RD_RESULT, 3'h0, 3'h3);
    check({rx[0], rx[1], rx[2]} === {res.temp, crc(res.temp)}, "auto result");
    send(CMD_MEAS_ONCE, 3'h0, 16'h0000, 8'h00);
    check(cmd_nack === 1'b1, "measure taken in auto mode");
    send(htr_cmd_e'(4'hF), 3'h0, 16'h0000, 8'h00);
    check(cmd_nack === 1'b1, "unknown command taken");
    want = 3'h3;
    send(CMD_RD_STATUS, 3'h0, 16'h0000, 8'h00);
    send(CMD_RD_LIMIT, 3'h0, 16'h0000, 8'h00);
    check(cmd_nack === 1'b1, "read taken while busy");
    tick(100);
    check(rx_n === 3'h3 && tx_active === 1'b0, "status length");
    send(CMD_HEATER_OFF, 3'h0, 16'h0000, 8'h00);
    send(CMD_SOFT_RESET, 3'h0, 16'h0000, 8'h00);
    tick(3);
    check({meas_busy, heater_en, alert, tx_active} === 4'h0, "not asleep");
    complete_run();
  end
endmodule
